// File: src/sbc_control.sv
// control and bus logic of a 12-bit successive-approximation converter
`timescale 1ns/100ps
`default_nettype none
`include "sbc_regs.svh"
module sbc_control
  import sbc_pkg::*;
#(
  parameter int BIT_CYC = `SBC_BIT_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic chip_enable,
  input wire logic select_n,
  input wire logic read_convert_n,
  input wire logic width_select,
  input wire logic byte_short_cycle_select,
  input wire logic comparator_high,
  output logic [11:0] dac_code,
  output logic conversion_busy,
  output logic [11:0] data_out,
  output logic [11:0] data_oe,
  input wire logic [`SBC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SBC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  // trial code, comparator sync and decision need four cycles per bit
  if (BIT_CYC < 4) begin : g_bit_cyc_chk
    $error("sbc_control: BIT_CYC must be at least 4");
  end

  // pins pass two flops; comparator too
  logic [5:0] pins_s;
  sbc_sync #(.W(6)) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .d({comparator_high, byte_short_cycle_select, width_select, read_convert_n, select_n,
        chip_enable}),
    .q(pins_s)
  );
  logic ce_s, cs_n_s, rc_s, wid_s, bsel_s, cmp_s;
  assign {cmp_s, bsel_s, wid_s, rc_s, cs_n_s, ce_s} = pins_s;

  // decoded selection; enable low or select high means no operation
  logic selected, start_cond;
  assign selected = ce_s && !cs_n_s;
  assign start_cond = selected && !rc_s;

  sbc_state_t state, next_state;
  logic start_prev, next_start_prev;
  logic short_cycle, next_short_cycle;
  sbc_code_t sar, next_sar;
  sbc_code_t trial, next_trial;
  sbc_code_t result, next_result;
  logic [3:0] bit_idx, next_bit_idx;
  logic next_busy;
  logic ev_done, ev_ignored, tick, sample_en;
  logic [1:0] warm, next_warm;

  sbc_bit_timer #(.PERIOD(BIT_CYC)) u_timer (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .run(state == SBC_CONVERT),
    .tick(tick)
  );

  // end of conversion index: 12-bit stops at bit 0, 8-bit at bit 4
  function automatic logic [3:0] last_bit(input logic short_c);
    last_bit = short_c ? 4'h4 : 4'h0;
  endfunction : last_bit

  // conversion sequencer
  always_comb begin
    next_state = state;
    next_warm = {warm[0], 1'b1};
    next_start_prev = start_cond || !warm[1]; // no false edge while sync fills
    next_short_cycle = short_cycle;
    next_sar = sar;
    next_trial = trial;
    next_result = result;
    next_bit_idx = bit_idx;
    next_busy = conversion_busy;
    ev_done = 1'b0;
    ev_ignored = 1'b0;
    unique case (state)
      SBC_IDLE: begin
        // rising edge of combined condition: last input to arrive starts it
        if (start_cond && !start_prev && sample_en) begin
          next_short_cycle = bsel_s;
          next_bit_idx = 4'hb;
          next_sar = 12'h000;
          next_trial = 12'h800;
          next_busy = 1'b1;
          next_state = SBC_CONVERT;
        end
      end
      SBC_CONVERT: begin
        if (start_cond && !start_prev) begin
          ev_ignored = 1'b1;
        end
        // one decision per bit period
        if (tick) begin
          if (cmp_s) begin
            next_sar = sar | trial;
          end
          next_trial = trial >> 1;
          if (bit_idx == last_bit(short_cycle)) begin
            next_state = SBC_LOAD;
          end else begin
            next_bit_idx = bit_idx - 4'h1;
          end
        end
      end
      SBC_LOAD: begin
        // latched on the same edge that busy falls; short result gets bit 3 set, 2..0 clear
        next_result = short_cycle ? {sar[11:4], 4'h8} : sar;
        next_busy = 1'b0;
        ev_done = 1'b1;
        next_state = SBC_IDLE;
      end
      default: begin
        next_state = SBC_IDLE;
        next_busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= SBC_IDLE;
      start_prev <= 1'b1;
      warm <= 2'b00;
      short_cycle <= 1'b0;
      sar <= '0;
      trial <= '0;
      result <= '0;
      bit_idx <= '0;
      conversion_busy <= 1'b0;
    end else begin
      state <= next_state;
      start_prev <= next_start_prev;
      warm <= next_warm;
      short_cycle <= next_short_cycle;
      sar <= next_sar;
      trial <= next_trial;
      result <= next_result;
      bit_idx <= next_bit_idx;
      conversion_busy <= next_busy;
    end
  end

  // output drivers; enables drop one cycle before the other byte comes on
  logic [11:0] next_data_out, next_data_oe;
  logic [11:0] next_dac_code;
  always_comb begin
    next_data_out = data_out;
    next_data_oe = 12'h000;
    next_dac_code = (state == SBC_CONVERT) ? (sar | trial) : 12'h000;
    if (selected && rc_s && !conversion_busy && !next_busy) begin
      if (wid_s) begin
        next_data_out = result;
        next_data_oe = 12'hfff;
      end else if (!bsel_s) begin
        next_data_out = {result[11:4], 4'h0};
        next_data_oe = 12'hff0;
      end else begin
        next_data_out = {8'h00, result[3:0]};
        next_data_oe = 12'h0ff;
      end
      // break before make between the two bytes
      if ((data_oe[11:8] != 4'h0 && next_data_oe[11:8] == 4'h0) ||
          (data_oe[3:0] == 4'h0 && data_oe[11:4] != 8'h00 && next_data_oe[11:8] == 4'h0)) begin
        next_data_oe = 12'h000;
      end else if (data_oe[11:8] == 4'h0 && data_oe[7:0] != 8'h00 &&
                   next_data_oe[11:8] != 4'h0) begin
        next_data_oe = 12'h000;
      end
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      data_out <= '0;
      data_oe <= '0;
      dac_code <= '0;
    end else begin
      data_out <= next_data_out;
      data_oe <= next_data_oe;
      dac_code <= next_dac_code;
    end
  end

  // register file: ctrl, status, sticky events, mask
  logic [1:0] ctrl, next_ctrl;
  logic [`SBC_IRQ_W-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [`SBC_ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_bvalid, next_rvalid, next_irq;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic do_write;
  assign sample_en = ctrl[`SBC_CTRL_SAMPLE_EN];

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_ctrl = ctrl;
    next_irq_mask = irq_mask;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    next_irq_stat = irq_stat;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    do_write = aw_held && w_held && !s_axi_bvalid;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `SBC_RESP_OKAY;
      unique case (aw_addr)
        `SBC_OFF_CTRL: if (w_strb[0]) next_ctrl = w_data[1:0];
        `SBC_OFF_IRQ_STAT: if (w_strb[0]) next_irq_stat = irq_stat & ~w_data[1:0];
        `SBC_OFF_IRQ_MASK: if (w_strb[0]) next_irq_mask = w_data[1:0];
        `SBC_OFF_STATUS: ;
        default: next_bresp = `SBC_RESP_SLVERR;
      endcase
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // events set after the clear so a same-cycle event survives
    if (ev_done) next_irq_stat[`SBC_IRQ_DONE] = 1'b1;
    if (ev_ignored) next_irq_stat[`SBC_IRQ_IGNORED] = 1'b1;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = `SBC_RESP_OKAY;
      unique case (s_axi_araddr)
        `SBC_OFF_CTRL: next_rdata = {30'h0, ctrl};
        `SBC_OFF_STATUS: next_rdata = {short_cycle, 3'h0, result, 15'h0, conversion_busy};
        `SBC_OFF_IRQ_STAT: next_rdata = {30'h0, irq_stat};
        `SBC_OFF_IRQ_MASK: next_rdata = {30'h0, irq_mask};
        default: begin
          next_rdata = 32'h0;
          next_rresp = `SBC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      ctrl <= 2'b01;
      irq_stat <= '0;
      irq_mask <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SBC_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `SBC_RESP_OKAY;
      s_axi_rdata <= '0;
      irq <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      ctrl <= next_ctrl;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
      irq <= next_irq;
      // ready one cycle after valid while its slot is empty
      s_axi_awready <= !next_aw_held && s_axi_awvalid && !s_axi_awready;
      s_axi_wready <= !next_w_held && s_axi_wvalid && !s_axi_wready;
      s_axi_arready <= !next_rvalid && s_axi_arvalid && !s_axi_arready;
    end
  end
endmodule : sbc_control
`default_nettype wire

// File: src/sbc_regs.svh
// register map, field positions and timing counts of the converter control block
`ifndef SBC_REGS_SVH
`define SBC_REGS_SVH
`define SBC_ADDR_W 4
`define SBC_OFF_CTRL 4'h0
`define SBC_OFF_STATUS 4'h4
`define SBC_OFF_IRQ_STAT 4'h8
`define SBC_OFF_IRQ_MASK 4'hc
`define SBC_CTRL_SAMPLE_EN 0
`define SBC_CTRL_SAMPLE_BIT 1
`define SBC_IRQ_DONE 0
`define SBC_IRQ_IGNORED 1
`define SBC_IRQ_W 2
`define SBC_RESP_OKAY 2'b00
`define SBC_RESP_SLVERR 2'b10
`define SBC_SETUP_NS 50
`define SBC_CLK_PERIOD_NS 10
`define SBC_SETUP_CYC ((`SBC_SETUP_NS + `SBC_CLK_PERIOD_NS - 1) / `SBC_CLK_PERIOD_NS)
`define SBC_BIT_NS 1600
`define SBC_BIT_CYC (`SBC_BIT_NS / `SBC_CLK_PERIOD_NS)
`endif

// File: src/sbc_pkg.sv
// types shared by the converter control block
package sbc_pkg;
  typedef enum logic [1:0] {
    SBC_IDLE,
    SBC_CONVERT,
    SBC_LOAD
  } sbc_state_t;
  typedef logic [11:0] sbc_code_t;
endpackage : sbc_pkg

// File: src/sbc_sync.sv
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/100ps
`default_nettype none
module sbc_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;
  // first stage feeds only the second
  always_comb begin
    next_meta = d;
    next_q = meta;
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule : sbc_sync
`default_nettype wire

// File: src/sbc_bit_timer.sv
// divider giving one enable pulse per successive-approximation bit period
`timescale 1ns/100ps
`default_nettype none
module sbc_bit_timer #(
  parameter int PERIOD = 160
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic run,
  output logic tick
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic next_tick;
  if (PERIOD < 1 || PERIOD > 65535) begin : g_period_chk
    $error("sbc_bit_timer: PERIOD out of range");
  end
  // count while running, pulse at wrap, restart when stopped
  always_comb begin
    next_cnt = cnt;
    next_tick = 1'b0;
    if (!run) begin
      next_cnt = '0;
    end else if (cnt == 16'(PERIOD - 1)) begin
      next_cnt = '0;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + 16'h0001;
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule : sbc_bit_timer
`default_nettype wire

// File: verification/sbc_checker.sv
// concurrent checks on the converter control pins
`timescale 1ns/100ps
`default_nettype none
module sbc_checker #(
  parameter int BIT_CYC = 4
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic chip_enable,
  input wire logic select_n,
  input wire logic read_convert_n,
  input wire logic width_select,
  input wire logic byte_short_cycle_select,
  input wire logic conversion_busy,
  input wire logic [11:0] data_out,
  input wire logic [11:0] data_oe
);
  localparam int L8 = 8 * BIT_CYC;
  localparam int L12 = 12 * BIT_CYC;
  logic [15:0] cnt, next_cnt;
  logic short_conv, next_short_conv;
  logic start;
  // busy length and length mode captured at start
  always_comb begin
    next_cnt = conversion_busy ? cnt + 16'h0001 : 16'h0000;
    next_short_conv = (conversion_busy && cnt == 16'h0000) ? byte_short_cycle_select : short_conv;
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 16'h0000;
      short_conv <= 1'b0;
    end else begin
      cnt <= next_cnt;
      short_conv <= next_short_conv;
    end
  end
  assign start = chip_enable && !select_n && !read_convert_n;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  busy_hiz_a: assert property (conversion_busy |-> data_oe == 12'h000)
    else $error("lines driven while busy");
  oe_shape_a: assert property (data_oe inside {12'h000, 12'hfff, 12'hff0, 12'h0ff})
    else $error("bad enable pattern");
  bbm_up_a: assert property (data_oe == 12'h0ff |-> $past(data_oe) != 12'hff0)
    else $error("no break before low byte");
  bbm_lo_a: assert property (data_oe == 12'hff0 |-> $past(data_oe) != 12'h0ff)
    else $error("no break before high byte");
  oe_cond_a: assert property (|data_oe |->
      $past(chip_enable, 3) && !$past(select_n, 3) && $past(read_convert_n, 3))
    else $error("lines driven without read");
  full_width_a: assert property (|data_oe && $past(width_select, 3) |-> data_oe == 12'hfff)
    else $error("partial word read");
  short_lsb_a: assert property (data_oe == 12'hfff && short_conv |-> data_out[3:0] == 4'h8)
    else $error("short result tail wrong");
  low_zero_a: assert property (data_oe == 12'h0ff |-> data_out[7:4] == 4'h0)
    else $error("trailing zeros missing");
  // bit periods plus the registered first tick and the load cycle
  busy_len_a: assert property ($fell(conversion_busy) |-> (short_conv ?
      (cnt == L8 + 1 || cnt == L8 + 2) : (cnt == L12 + 1 || cnt == L12 + 2)))
    else $error("busy length wrong");
  start_cause_a: assert property ($rose(conversion_busy) |-> $past(start, 3))
    else $error("busy without start");
  start_busy_a: assert property ($rose(start) && !conversion_busy |-> ##[1:8] conversion_busy)
    else $error("start not taken");
endmodule : sbc_checker
bind sbc_control sbc_checker #(.BIT_CYC(BIT_CYC)) sbc_checker_inst (
  .ref_clk, .resetn, .chip_enable, .select_n, .read_convert_n, .width_select,
  .byte_short_cycle_select, .conversion_busy, .data_out, .data_oe);
`default_nettype wire

// File: verification/sbc_comp_model.sv
// ideal comparator facing the trial code
`timescale 1ns/100ps
`default_nettype none
module sbc_comp_model (
  input wire logic [11:0] dac_code,
  input wire logic [11:0] level,
  output logic comparator_high
);
  // keep the trial bit while the code does not exceed the held input
  assign comparator_high = dac_code <= level;
endmodule : sbc_comp_model
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
`include "sbc_regs.svh"
module tb_top;
  logic ref_clk, resetn, ce, csn, rc, wsel, bsel, cmp, busy, irq;
  logic [11:0] dac, dout, doe, lvl;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0] bresp, rresp;
  int error_cnt, n_tests, cyc;
  sbc_comp_model sbc_comp_model_inst (.dac_code(dac), .level(lvl), .comparator_high(cmp));
  sbc_control #(.BIT_CYC(4)) sbc_control_inst (
    .ref_clk(ref_clk), .resetn(resetn), .chip_enable(ce), .select_n(csn),
    .read_convert_n(rc), .width_select(wsel), .byte_short_cycle_select(bsel),
    .comparator_high(cmp), .dac_code(dac), .conversion_busy(busy), .data_out(dout),
    .data_oe(doe), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // cycle ceiling against a hung wait
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // pins as {enable, select_n, read_convert_n, width, byte}
  task automatic pins(input logic [4:0] v);
    @(posedge ref_clk);
    {ce, csn, rc, wsel, bsel} <= v;
  endtask : pins
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle
  task automatic wait_busy(input logic lv);
    int n;
    n = 0;
    while (busy !== lv && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    chk(busy, lv);
  endtask : wait_busy
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, `SBC_RESP_OKAY);
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    chk(rresp, er);
  endtask : axi_rd
  // one conversion in stand-alone wiring, read strobe raised during busy
  task automatic conv(input logic b);
    pins({4'b1001, b});
    wait_busy(1'b1);
    pins({4'b1011, b});
    idle(6);
    chk(doe, 12'h000);
    wait_busy(1'b0);
    idle(6);
  endtask : conv
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    resetn = 1'b0;
    {ce, csn, rc, wsel, bsel} = 5'b10110;
    lvl = 12'ha5c;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    axi_rd(`SBC_OFF_CTRL, `SBC_RESP_OKAY, rd);
    chk(rd[0], 1'b1);
    axi_rd(`SBC_OFF_IRQ_MASK, `SBC_RESP_OKAY, rd);
    chk(rd, 32'h0);
    axi_rd(4'h2, `SBC_RESP_SLVERR, rd);
    $display("test registers done");
    conv(1'b0);
    chk(doe, 12'hfff);
    chk(dout, 12'ha5c);
    axi_rd(`SBC_OFF_STATUS, `SBC_RESP_OKAY, rd);
    chk(rd[27:16], 12'ha5c);
    $display("test full conversion done");
    lvl <= 12'h3c7;
    conv(1'b1);
    chk(doe, 12'hfff);
    chk(dout, 12'h3c8);
    pins(5'b10100);
    idle(6);
    chk(doe, 12'hff0);
    chk(dout[11:4], 8'h3c);
    pins(5'b10101);
    idle(6);
    chk(doe, 12'h0ff);
    chk(dout[7:0], 8'h08);
    $display("test byte reads done");
    axi_wr(`SBC_OFF_IRQ_STAT, 32'h3);
    pins(5'b10010);
    wait_busy(1'b1);
    pins(5'b10111);
    idle(3);
    pins(5'b10011);
    idle(4);
    pins(5'b10111);
    wait_busy(1'b0);
    idle(6);
    chk(dout, 12'h3c7);
    chk(irq, 1'b0);
    axi_rd(`SBC_OFF_IRQ_STAT, `SBC_RESP_OKAY, rd);
    chk(rd, 32'h3);
    axi_wr(`SBC_OFF_IRQ_MASK, 32'h3);
    idle(3);
    chk(irq, 1'b1);
    axi_wr(`SBC_OFF_IRQ_STAT, 32'h3);
    idle(3);
    chk(irq, 1'b0);
    $display("test restart and interrupt done");
    // hold one start input back, then let it finish the start
    for (int i = 0; i < 3; i++) begin
      pins(5'b10010 ^ (5'b10000 >> i));
      idle(10);
      chk(busy, 1'b0);
      pins(5'b10010);
      wait_busy(1'b1);
      pins(5'b10110);
      wait_busy(1'b0);
    end
    $display("test start inputs done");
    // start condition already present at reset release must not start
    resetn <= 1'b0;
    pins(5'b10010);
    idle(2);
    resetn <= 1'b1;
    idle(10);
    chk(busy, 1'b0);
    $display("test reset release done");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
